//--- rtl/lcd3_map.svh
`ifndef LCD3_MAP_SVH
`define LCD3_MAP_SVH

// Register indices; the byte address is four times the index.
`define LCD3_IDX_CNT31 10'h19e
`define LCD3_IDX_PHASE 10'h19f
`define LCD3_IDX_CNT32 10'h1a0
`define LCD3_IDX_CTRL 10'h1a1
`define LCD3_IDX_DCC 10'h1a2
`define LCD3_IDX_STAT 10'h1a3

// Field positions.
`define LCD3_LO_LSB 4
`define LCD3_HI_LSB 0
`define LCD3_BYP32_BIT 5
`define LCD3_BYP31_BIT 4
`define LCD3_NOSYNC_BIT 3
`define LCD3_FORCE_BIT 2
`define LCD3_START32_BIT 1
`define LCD3_START31_BIT 0
`define LCD3_DCCDIS_BIT 0

// Reset values.
`define LCD3_RST_PHASE 8'h00
`define LCD3_RST_CNT 8'h00
`define LCD3_RST_CTRL 6'h00
`define LCD3_RST_DCC 1'h0

`endif

//--- rtl/lcd3_pkg.sv
package lcd3_pkg;

   typedef enum logic {
      ph_low,
      ph_high
   } lcd3_phase_type;

   typedef enum logic [2:0] {
      reg_none,
      reg_cnt31,
      reg_phase,
      reg_cnt32,
      reg_ctrl,
      reg_dcc,
      reg_stat
   } lcd3_reg_type;

   typedef struct packed {
      logic [3:0] lo;
      logic [3:0] hi;
      logic byp;
      logic start_hi;
   } lcd3_div_cfg_type;

endpackage

//--- rtl/lcd3_channel.sv
// Summary of operation
// - Divider 3.2 low lasts low field plus one with correction off
// - Divider 3.2 high lasts high field plus one with correction off
// - Divider 3.1 timed alike from own fields
// - Two 4-bit phase settings, reset to zero
// - Bypass bit 5 powers down, passes 3.2
// - Bypass bit 4 powers down, passes 3.1
// - Bit 3 set ignores chip-level sync
// - With sync ignored, bit 2 forces chan_clk_out
// - Bit 1 sets divider 3.2 start level
// - Bit 0 sets divider 3.1 start level
// - Duty correction on unless disable bit set
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`include "lcd3_map.svh"
module lcd3_channel (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic nrst_in,
   // APB slave.
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Chip-level sync, active high.
   input wire logic sync_in,
   // Divider outputs.
   output logic div31_clk_out,
   output logic chan_clk_out
);

   function automatic lcd3_pkg::lcd3_reg_type lcd3_dec(input logic [31:0] a);
      lcd3_pkg::lcd3_reg_type r;
      r = lcd3_pkg::reg_none;
      if (a[31:12] == 20'h00000 && a[1:0] == 2'h0) begin
         unique case (a[11:2])
            `LCD3_IDX_CNT31: r = lcd3_pkg::reg_cnt31;
            `LCD3_IDX_PHASE: r = lcd3_pkg::reg_phase;
            `LCD3_IDX_CNT32: r = lcd3_pkg::reg_cnt32;
            `LCD3_IDX_CTRL: r = lcd3_pkg::reg_ctrl;
            `LCD3_IDX_DCC: r = lcd3_pkg::reg_dcc;
            `LCD3_IDX_STAT: r = lcd3_pkg::reg_stat;
            default: r = lcd3_pkg::reg_none;
         endcase
      end
      return r;
   endfunction

   // Last count of the current phase; correction halves the period, high taking the odd count.
   function automatic logic [3:0] lcd3_lim(input lcd3_pkg::lcd3_div_cfg_type c,
                                          input logic dcc,
                                          input lcd3_pkg::lcd3_phase_type ph);
      logic [5:0] tot;
      logic [5:0] hl;
      logic [5:0] ll;
      tot = {2'h0, c.lo} + {2'h0, c.hi} + 6'h02;
      hl = (tot + 6'h01) >> 1;
      ll = tot - hl;
      if (dcc) begin
         lcd3_lim = (ph == lcd3_pkg::ph_high) ? 4'(hl - 6'h01) : 4'(ll - 6'h01);
      end else begin
         lcd3_lim = (ph == lcd3_pkg::ph_high) ? c.hi : c.lo;
      end
   endfunction

   logic [7:0] phase_r, phase_nxt;
   logic [7:0] cnt31_r, cnt31_nxt;
   logic [7:0] cnt32_r, cnt32_nxt;
   logic [5:0] ctrl_r, ctrl_nxt;
   logic dcc_off_r, dcc_off_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic src_r, src_nxt;
   logic div31_r, div31_nxt;
   logic chan_r, chan_nxt;
   logic [3:0] cnt_r [2];
   logic [3:0] cnt_nxt [2];
   lcd3_pkg::lcd3_phase_type ph_r [2];
   lcd3_pkg::lcd3_phase_type ph_nxt [2];
   lcd3_pkg::lcd3_div_cfg_type cfg [2];
   lcd3_pkg::lcd3_reg_type sel;
   logic [3:0] lim [2];
   logic en_in [2];
   logic en_out [2];
   logic lvl_in [2];
   logic lvl_out [2];
   logic setup;
   logic wr;
   logic nosync;
   logic hold;
   logic dcc_on;

   assign sel = lcd3_dec(paddr_in);
   assign setup = psel_in && !penable_in;
   assign wr = psel_in && penable_in && pwrite_in && pready_r && pstrb_in[0];
   // Sync obeyed.
   // sync hold select
   assign nosync = ctrl_r[`LCD3_NOSYNC_BIT];
   assign hold = sync_in && !nosync;
   assign dcc_on = !dcc_off_r;

   assign cfg[0] = '{lo: cnt31_r[`LCD3_LO_LSB +: 4], hi: cnt31_r[`LCD3_HI_LSB +: 4],
                     byp: ctrl_r[`LCD3_BYP31_BIT], start_hi: ctrl_r[`LCD3_START31_BIT]};
   assign cfg[1] = '{lo: cnt32_r[`LCD3_LO_LSB +: 4], hi: cnt32_r[`LCD3_HI_LSB +: 4],
                     byp: ctrl_r[`LCD3_BYP32_BIT], start_hi: ctrl_r[`LCD3_START32_BIT]};

   // Source stand-in: the divider input clock sampled as a level.
   assign en_in[0] = 1'b1;
   assign lvl_in[0] = src_r;
   assign en_in[1] = en_out[0];
   assign lvl_in[1] = lvl_out[0];

   // Register file and APB answer.
   always_comb begin
      phase_nxt = phase_r;
      cnt31_nxt = cnt31_r;
      cnt32_nxt = cnt32_r;
      ctrl_nxt = ctrl_r;
      dcc_off_nxt = dcc_off_r;
      pready_nxt = setup;
      pslverr_nxt = setup && sel == lcd3_pkg::reg_none;
      prdata_nxt = 32'h00000000;
      if (wr) begin
         unique case (sel)
            lcd3_pkg::reg_cnt31: cnt31_nxt = pwdata_in[7:0];
            lcd3_pkg::reg_phase: phase_nxt = pwdata_in[7:0];
            lcd3_pkg::reg_cnt32: cnt32_nxt = pwdata_in[7:0];
            lcd3_pkg::reg_ctrl: ctrl_nxt = pwdata_in[5:0];
            lcd3_pkg::reg_dcc: dcc_off_nxt = pwdata_in[`LCD3_DCCDIS_BIT];
            default: ;
         endcase
      end
      if (setup && !pwrite_in) begin
         unique case (sel)
            lcd3_pkg::reg_cnt31: prdata_nxt = {24'h000000, cnt31_r};
            lcd3_pkg::reg_phase: prdata_nxt = {24'h000000, phase_r};
            lcd3_pkg::reg_cnt32: prdata_nxt = {24'h000000, cnt32_r};
            lcd3_pkg::reg_ctrl: prdata_nxt = {26'h0000000, ctrl_r};
            lcd3_pkg::reg_dcc: prdata_nxt = {31'h00000000, dcc_off_r};
            lcd3_pkg::reg_stat: prdata_nxt = {29'h00000000, hold, lvl_out[1], lvl_out[0]};
            default: prdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         phase_r <= `LCD3_RST_PHASE;
         cnt31_r <= `LCD3_RST_CNT;
         cnt32_r <= `LCD3_RST_CNT;
         ctrl_r <= `LCD3_RST_CTRL;
         dcc_off_r <= `LCD3_RST_DCC;
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         cnt31_r <= cnt31_nxt;
         cnt32_r <= cnt32_nxt;
         ctrl_r <= ctrl_nxt;
         dcc_off_r <= dcc_off_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata_out = prdata_r;
   assign pready_out = pready_r;
   assign pslverr_out = pslverr_r;

   for (genvar g = 0; g < 2; g++) begin : g_div
      // Correction acts on the final stage only.
      assign lim[g] = lcd3_lim(cfg[g], dcc_on && g == 1, ph_r[g]);
      assign lvl_out[g] = cfg[g].byp ? lvl_in[g] : ph_r[g] == lcd3_pkg::ph_high;
      assign en_out[g] = cfg[g].byp ? en_in[g] :
                         en_in[g] && !hold && ph_r[g] == lcd3_pkg::ph_low && cnt_r[g] == lim[g];

      always_comb begin
         cnt_nxt[g] = cnt_r[g];
         ph_nxt[g] = ph_r[g];
         if (hold || cfg[g].byp) begin
            cnt_nxt[g] = 4'h0;
            if (hold) begin
               ph_nxt[g] = cfg[g].start_hi ? lcd3_pkg::ph_high : lcd3_pkg::ph_low;
            end
         end else if (en_in[g]) begin
            if (cnt_r[g] == lim[g]) begin
               cnt_nxt[g] = 4'h0;
               ph_nxt[g] = (ph_r[g] == lcd3_pkg::ph_high) ? lcd3_pkg::ph_low : lcd3_pkg::ph_high;
            end else begin
               cnt_nxt[g] = cnt_r[g] + 4'h1;
            end
         end
      end

      always_ff @(posedge clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            cnt_r[g] <= 4'h0;
            ph_r[g] <= lcd3_pkg::ph_low;
         end else begin
            cnt_r[g] <= cnt_nxt[g];
            ph_r[g] <= ph_nxt[g];
         end
      end
   end

   // Output stage.
   always_comb begin
      src_nxt = !src_r;
      div31_nxt = lvl_out[0];
      chan_nxt = nosync ? ctrl_r[`LCD3_FORCE_BIT] : lvl_out[1];
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         src_r <= 1'b0;
         div31_r <= 1'b0;
         chan_r <= 1'b0;
      end else begin
         src_r <= src_nxt;
         div31_r <= div31_nxt;
         chan_r <= chan_nxt;
      end
   end

   assign div31_clk_out = div31_r;
   assign chan_clk_out = chan_r;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   a_d32_low_end: assert property (
      !cfg[1].byp && !hold && !dcc_on && en_in[1] && ph_r[1] == lcd3_pkg::ph_low
      && cnt_r[1] == cnt32_r[7:4] |=> ph_r[1] == lcd3_pkg::ph_high)
      else $error("Divider 3.2 low phase did not end on time.");

   a_d32_high_end: assert property (
      !cfg[1].byp && !hold && !dcc_on && en_in[1] && ph_r[1] == lcd3_pkg::ph_high
      && cnt_r[1] < cnt32_r[3:0] |=> ph_r[1] == lcd3_pkg::ph_high)
      else $error("Divider 3.2 high phase ended early.");

   a_d31_period: assert property (
      !cfg[0].byp && !hold && ph_r[0] == lcd3_pkg::ph_high && cnt_r[0] == cnt31_r[3:0]
      ##1 !cfg[0].byp && !hold |-> ph_r[0] == lcd3_pkg::ph_low)
      else $error("Divider 3.1 high phase length wrong.");

   a_phase_stable: assert property (
      !$stable(phase_r) |-> $past(wr) && $past(sel) == lcd3_pkg::reg_phase)
      else $error("Phase setting changed without a write.");

   a_d32_bypass: assert property (
      cfg[1].byp && !nosync |=> cnt_r[1] == 4'h0 && chan_clk_out == $past(lvl_out[0]))
      else $error("Divider 3.2 bypass not passing its input.");

   a_d31_bypass: assert property (
      cfg[0].byp |=> cnt_r[0] == 4'h0 && div31_clk_out == $past(src_r))
      else $error("Divider 3.1 bypass not passing its input.");

   a_sync_ignore: assert property (
      nosync && !cfg[0].byp && ph_r[0] == lcd3_pkg::ph_low && cnt_r[0] != cnt31_r[7:4]
      && $stable(ctrl_r) |=> cnt_r[0] == $past(cnt_r[0]) + 4'h1)
      else $error("Sync-ignore divider stopped counting.");

   a_force_level: assert property (
      nosync ##1 nosync |-> chan_clk_out == $past(ctrl_r[`LCD3_FORCE_BIT]))
      else $error("Forced output level not applied.");

   a_start32: assert property (
      hold ##1 hold |-> (ph_r[1] == lcd3_pkg::ph_high) == $past(ctrl_r[`LCD3_START32_BIT]))
      else $error("Divider 3.2 start level wrong.");

   a_start31: assert property (
      hold ##1 hold |-> (ph_r[0] == lcd3_pkg::ph_high) == $past(ctrl_r[`LCD3_START31_BIT]))
      else $error("Divider 3.1 start level wrong.");

   a_dcc_split: assert property (
      dcc_on && !cfg[1].byp && !hold && cnt32_r == 8'h20 && en_in[1]
      && ph_r[1] == lcd3_pkg::ph_high && cnt_r[1] == 4'h1 |=> ph_r[1] == lcd3_pkg::ph_low)
      else $error("Duty correction did not even the period.");

   a_cascade: assert property (
      !cfg[0].byp && !cfg[1].byp && !hold
      ##1 (cnt_r[1] != $past(cnt_r[1]) || ph_r[1] != $past(ph_r[1]))
      |-> ph_r[0] == lcd3_pkg::ph_high && $past(ph_r[0]) == lcd3_pkg::ph_low)
      else $error("Divider 3.2 stepped without a 3.1 edge.");

   c_div_run: cover property (!hold && !nosync && $rose(chan_clk_out));
   c_bypass_both: cover property (cfg[0].byp && cfg[1].byp ##1 $rose(chan_clk_out));
   c_forced_high: cover property (nosync && ctrl_r[`LCD3_FORCE_BIT] ##1 chan_clk_out);
   c_sync_release: cover property (hold ##1 !hold);

endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   localparam logic [31:0] A_C31 = 32'h19e * 4;
   localparam logic [31:0] A_PH = 32'h19f * 4;
   localparam logic [31:0] A_C32 = 32'h1a0 * 4;
   localparam logic [31:0] A_CT = 32'h1a1 * 4;
   localparam logic [31:0] A_DC = 32'h1a2 * 4;
   localparam logic [31:0] A_ST = 32'h1a3 * 4;
   logic clk_in, nrst_in, psel, pen, pwr, sync, pready, perr, d31, chan, er;
   logic [31:0] paddr, pwdata, prdata, rd, v;
   logic [3:0] pstrb;
   logic [3:0] c [4];
   int num_errors = 0;
   int n_tests = 0;
   int h, l;

   lcd3_channel u_lcd3_channel (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
      .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
      .sync_in(sync), .div31_clk_out(d31), .chan_clk_out(chan));

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // The request stands until pready is sampled high at a rising edge.
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      pen <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (pready !== 1'b1);
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   function automatic logic sig(input bit ch);
      return ch ? chan : d31;
   endfunction

   // Sees one full high phase followed by one full low phase.
   task automatic meas(input bit ch, output int hi, output int lo);
      int n;
      hi = 0;
      lo = 0;
      n = 0;
      while (sig(ch) !== 1'b0 && n < 5000) begin
         @(posedge clk_in);
         n++;
      end
      while (sig(ch) !== 1'b1 && n < 5000) begin
         @(posedge clk_in);
         n++;
      end
      while (sig(ch) === 1'b1 && hi < 5000) begin
         @(posedge clk_in);
         hi++;
      end
      while (sig(ch) === 1'b0 && lo < 5000) begin
         @(posedge clk_in);
         lo++;
      end
   endtask

   task automatic meas2(input bit ch);
      meas(ch, h, l);
      meas(ch, h, l);
   endtask

   task automatic hold(input string nm, input bit ch, input logic e);
      int bad;
      bad = 0;
      repeat (5) @(posedge clk_in);
      repeat (20) begin
         @(posedge clk_in);
         if (sig(ch) !== e) bad++;
      end
      chk(nm, 32'h0, bad);
   endtask

   function automatic int exp_len(input int dc, input bit hi);
      int q, p;
      q = c[0] + c[1] + 2;
      p = c[2] + c[3] + 2;
      if (dc != 0) return q * (hi ? c[3] + 1 : c[2] + 1);
      return q * (hi ? (p + 1) / 2 : p / 2);
   endfunction

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   initial begin
      #800000;
      num_errors++;
      $display("watchdog expired");
      test_done();
   end

   initial begin
      nrst_in = 1'b0;
      {psel, pen, pwr, sync} = 4'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      v = $urandom(92);
      repeat (10) @(posedge clk_in);
      nrst_in <= 1'b1;
      rdc("cnt31 reset", A_C31, 32'h0);
      rdc("phase reset", A_PH, 32'h0);
      rdc("cnt32 reset", A_C32, 32'h0);
      rdc("ctrl reset", A_CT, 32'h0);
      rdc("dcc reset", A_DC, 32'h0);
      v = 32'($urandom_range(255));
      apb(1'b1, A_PH, v);
      rdc("phase", A_PH, v);
      pstrb <= 4'h0;
      apb(1'b1, A_PH, ~v & 32'hff);
      pstrb <= 4'hf;
      rdc("phase no strobe", A_PH, v);
      apb(1'b0, 32'h690, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
      $display("test registers done");
      for (int i = 0; i < 5; i++) begin
         foreach (c[k]) c[k] = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom_range(15));
         // Corner case: divider 3.2 period of four, split evenly by correction.
         if (i == 4) begin
            c[2] = 4'h2;
            c[3] = 4'h0;
         end
         apb(1'b1, A_C31, {24'h0, c[0], c[1]});
         apb(1'b1, A_C32, {24'h0, c[2], c[3]});
         for (int dc = 1; dc >= 0; dc--) begin
            apb(1'b1, A_DC, 32'(dc));
            meas2(1'b0);
            chk("div31 high", c[1] + 1, h);
            chk("div31 low", c[0] + 1, l);
            meas2(1'b1);
            chk("chan high", exp_len(dc, 1'b1), h);
            chk("chan low", exp_len(dc, 1'b0), l);
         end
         $display("test divide %0d done", i);
      end
      apb(1'b1, A_DC, 32'h1);
      apb(1'b1, A_CT, 32'h20);
      meas2(1'b1);
      chk("bypass32 high", c[1] + 1, h);
      chk("bypass32 low", c[0] + 1, l);
      apb(1'b1, A_CT, 32'h10);
      meas2(1'b0);
      chk("bypass31 high", 32'h1, h);
      chk("bypass31 low", 32'h1, l);
      $display("test bypass done");
      apb(1'b1, A_CT, 32'h0c);
      sync <= 1'b1;
      hold("force high", 1'b1, 1'b1);
      meas2(1'b0);
      chk("nosync div31 high", c[1] + 1, h);
      apb(1'b1, A_CT, 32'h08);
      hold("force low", 1'b1, 1'b0);
      $display("test force done");
      apb(1'b1, A_CT, 32'h03);
      hold("start31 high", 1'b0, 1'b1);
      hold("start32 high", 1'b1, 1'b1);
      rdc("hold status", A_ST, 32'h7);
      apb(1'b1, A_CT, 32'h00);
      hold("start31 low", 1'b0, 1'b0);
      hold("start32 low", 1'b1, 1'b0);
      sync <= 1'b0;
      meas2(1'b0);
      chk("released div31 high", c[1] + 1, h);
      $display("test sync done");
      test_done();
   end
endmodule
